// [bbpc_pkg.sv]
// shared constants, field layouts and carriers for the bridge window and capability registers
package bbpc_pkg;

    // register byte offsets in configuration space
    localparam logic [7:0]  BBPC_OFF_XBASE      = 8'hA8;
    localparam logic [7:0]  BBPC_OFF_SETUP      = 8'hAC;
    localparam logic [7:0]  BBPC_OFF_CAPHDR     = 8'hB0;
    localparam logic [7:0]  BBPC_OFF_DEVCAP     = 8'hB4;

    // setup register field positions
    localparam int          BBPC_TYPE_BIT       = 0;
    localparam int          BBPC_ATYPE_LSB      = 1;
    localparam int          BBPC_ATYPE_MSB      = 2;
    localparam int          BBPC_PREF_BIT       = 3;
    localparam int          BBPC_SIZE_LSB       = 6;
    localparam int          BBPC_SIZE_MSB       = 30;
    localparam int          BBPC_EN_BIT         = 31;

    // address type encodings
    localparam logic [1:0]  BBPC_ATYPE_32       = 2'h0;
    localparam logic [1:0]  BBPC_ATYPE_64       = 2'h1;

    // writable setup bits: enable, size mask, prefetch, low address-type bit
    localparam logic [31:0] BBPC_SETUP_WMASK    = 32'hFFFFFFCA;
    localparam logic [31:0] BBPC_SETUP_RST      = 32'h00000000;
    localparam logic [25:0] BBPC_XBASE_RST      = 26'h0000000;

    // capability header and device capability constants
    localparam logic [7:0]  BBPC_CAP_ID         = 8'h10;
    localparam logic [7:0]  BBPC_NEXT_PTR       = 8'hF0;
    localparam logic [3:0]  BBPC_CAP_VER        = 4'h1;
    localparam logic [3:0]  BBPC_PORT_FWD       = 4'h7;
    localparam logic [3:0]  BBPC_PORT_REV       = 4'h8;
    localparam logic [4:0]  BBPC_MSG_NUM        = 5'h00;
    localparam logic [2:0]  BBPC_MPS            = 3'h2;
    localparam logic [1:0]  BBPC_PHANTOM        = 2'h0;
    localparam logic        BBPC_TAG8           = 1'b1;
    localparam logic [2:0]  BBPC_L0S_LAT        = 3'h0;
    localparam logic [2:0]  BBPC_L1_LAT         = 3'h0;
    localparam logic [7:0]  BBPC_PWR_VAL_RST    = 8'h00;
    localparam logic [1:0]  BBPC_PWR_SCL_RST    = 2'h0;

    // one register request as seen at the completing edge
    typedef struct packed {
        logic        write;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } bbpc_req_s;

    // translation window as handed to the datapath
    typedef struct packed {
        logic        en;
        logic        addr64;
        logic        pref;
        logic [25:0] base;
        logic [25:0] size_mask;
    } bbpc_win_s;

    // slot power limit message payload
    typedef struct packed {
        logic        valid;
        logic [7:0]  value;
        logic [1:0]  scale;
    } bbpc_pwr_s;

    // keep old bits where mask is 0, take new bits where mask is 1
    function automatic logic [31:0] bbpc_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                               input logic [31:0] mask);
        bbpc_merge = (old_v & ~mask) | (new_v & mask);
    endfunction

endpackage

// [bbpc_apb.sv]
// apb slave handshake: one wait state, read data latched, write strobe at completion
`timescale 1ns/100ps
module bbpc_apb (
    input  wire logic             clock,
    input  wire logic             rst,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic [31:0]      rd_word,
    input  wire logic             hit,
    output logic                  pready,
    output logic [31:0]           prdata,
    output logic                  pslverr,
    output logic                  wr_en
);
    import bbpc_pkg::*;

    typedef enum logic [0:0] {BBPC_ST_IDLE = 1'b0, BBPC_ST_ANS = 1'b1} bbpc_st_e;
    bbpc_st_e st_q;

    // answer one cycle after the access phase opens, then drop ready
    always_ff @(posedge clock) begin
        if (rst) begin
            st_q    <= BBPC_ST_IDLE;
            pready  <= 1'b0;
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end else begin
            case (st_q)
                BBPC_ST_IDLE: begin
                    if (psel && penable) begin
                        st_q    <= BBPC_ST_ANS;
                        pready  <= 1'b1;
                        prdata  <= rd_word;
                        pslverr <= ~hit;
                    end
                end
                BBPC_ST_ANS: begin
                    st_q    <= BBPC_ST_IDLE;
                    pready  <= 1'b0;
                    pslverr <= 1'b0;
                end
                default: begin
                    st_q   <= BBPC_ST_IDLE;
                    pready <= 1'b0;
                end
            endcase
        end
    end

    // the write lands only on the edge where the master samples ready
    assign wr_en = (st_q == BBPC_ST_ANS) && psel && penable && hit;

endmodule // bbpc_apb

// [bbpc_pwr_capture.sv]
// captures slot power limit value and scale from the incoming message
`timescale 1ns/100ps
module bbpc_pwr_capture (
    input  wire logic             clock,
    input  wire logic             rst,
    input  wire bbpc_pkg::bbpc_pwr_s msg,
    output logic [7:0]            value_q,
    output logic [1:0]            scale_q
);
    import bbpc_pkg::*;

    // software cannot write these; only the message moves them
    always_ff @(posedge clock) begin
        if (rst) begin
            value_q <= BBPC_PWR_VAL_RST;
            scale_q <= BBPC_PWR_SCL_RST;
        end else if (msg.valid) begin
            value_q <= msg.value;
            scale_q <= msg.scale;
        end
    end

    a_pwr_capture_msg: assert property (@(posedge clock) disable iff (rst)
        msg.valid |=> (value_q == $past(msg.value)) && (scale_q == $past(msg.scale)))
        else $error("slot power limit not captured from message");

    a_pwr_hold_idle: assert property (@(posedge clock) disable iff (rst)
        !msg.valid |=> $stable(value_q) && $stable(scale_q))
        else $error("slot power limit moved without a message");

endmodule // bbpc_pwr_capture

// [bbpc_regs.sv]
// configuration registers: downstream window setup, translated base, express capability words
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/100ps
module bbpc_regs (
    input  wire logic                 clock,
    input  wire logic                 rst,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [7:0]           paddr,
    input  wire logic [31:0]          pwdata,
    output logic [31:0]               prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire logic                 reverse_strap,
    input  wire logic                 hotplug_strap,
    input  wire bbpc_pkg::bbpc_pwr_s  slot_pwr,
    output bbpc_pkg::bbpc_win_s       win_q
);
    import bbpc_pkg::*;

    logic                 reverse_q;
    logic                 hotplug_q;
    logic [31:0]          setup_q;
    logic [25:0]          xbase_q;
    logic [7:0]           pwr_val_q;
    logic [1:0]           pwr_scl_q;
    logic                 wr_en;
    logic                 hit;
    logic [31:0]          rd_word;
    logic [31:0]          setup_word;
    logic [31:0]          xbase_word;
    logic [31:0]          caphdr_word;
    logic [31:0]          devcap_word;
    logic [25:0]          base_wmask;
    logic [31:0]          xbase_merge;
    logic                 hp_present;
    bbpc_req_s            req;

    // request as presented on the bus; valid while psel and penable hold
    assign req.write = pwrite;
    assign req.addr  = paddr;
    assign req.wdata = pwdata;

    // straps are sampled while reset is held, so mode is fixed from the release on
    always_ff @(posedge clock) begin
        if (rst) begin
            reverse_q <= reverse_strap;
            hotplug_q <= hotplug_strap;
        end
    end

    // bus handshake and answer timing live in the front end
    bbpc_apb u_apb (
        .clock   (clock),
        .rst     (rst),
        .psel    (psel),
        .penable (penable),
        .rd_word (rd_word),
        .hit     (hit),
        .pready  (pready),
        .prdata  (prdata),
        .pslverr (pslverr),
        .wr_en   (wr_en)
    );

    // message capture keeps its own flops; the read path only samples them
    bbpc_pwr_capture u_pwr (
        .clock   (clock),
        .rst     (rst),
        .msg     (slot_pwr),
        .value_q (pwr_val_q),
        .scale_q (pwr_scl_q)
    );

    // address decode: four words answer, everything else is an error
    always_comb begin
        case (req.addr)
            BBPC_OFF_XBASE:  hit = 1'b1;
            BBPC_OFF_SETUP:  hit = 1'b1;
            BBPC_OFF_CAPHDR: hit = 1'b1;
            BBPC_OFF_DEVCAP: hit = 1'b1;
            default:         hit = 1'b0;
        endcase
    end

    // setup write: only mask-listed bits move; type bit, bit 2 and 5:4 stay zero
    always_ff @(posedge clock) begin
        if (rst) begin
            setup_q <= BBPC_SETUP_RST;
        end else if (wr_en && req.write && req.addr == BBPC_OFF_SETUP) begin
            setup_q <= bbpc_merge(setup_q, req.wdata, BBPC_SETUP_WMASK);
        end
    end

    // bit 31 of the base has no size bit and always takes writes
    assign base_wmask = {1'b1, setup_q[BBPC_SIZE_MSB:BBPC_SIZE_LSB]};

    // merge at full word width; the top six bits are only padding and are cut off below
    assign xbase_merge = bbpc_merge({6'h00, xbase_q}, {6'h00, req.wdata[31:6]}, {6'h00, base_wmask});

    // translated base write; cleared mask bits hold their old value
    always_ff @(posedge clock) begin
        if (rst) begin
            xbase_q <= BBPC_XBASE_RST;
        end else if (wr_en && req.write && req.addr == BBPC_OFF_XBASE) begin
            xbase_q <= xbase_merge[25:0];
        end
    end

    // window handed to the datapath, one cycle behind the registers
    always_ff @(posedge clock) begin
        if (rst) begin
            win_q <= '0;
        end else begin
            win_q.en        <= setup_q[BBPC_EN_BIT];
            win_q.addr64    <= (setup_q[BBPC_ATYPE_MSB:BBPC_ATYPE_LSB] == BBPC_ATYPE_64);
            win_q.pref      <= setup_q[BBPC_PREF_BIT];
            win_q.base      <= xbase_q & base_wmask;
            win_q.size_mask <= base_wmask;
        end
    end

    // hot-plug indicators only exist for a forward bridge with the strap set
    assign hp_present = hotplug_q & ~reverse_q;

    // setup word as read back; unlisted bits read zero
    always_comb begin
        setup_word                = 32'h00000000;
        setup_word[BBPC_TYPE_BIT] = 1'b0;
        setup_word[BBPC_ATYPE_MSB:BBPC_ATYPE_LSB] = setup_q[BBPC_ATYPE_MSB:BBPC_ATYPE_LSB];
        setup_word[BBPC_PREF_BIT] = setup_q[BBPC_PREF_BIT];
        setup_word[BBPC_SIZE_MSB:BBPC_SIZE_LSB] = setup_q[BBPC_SIZE_MSB:BBPC_SIZE_LSB];
        setup_word[BBPC_EN_BIT]   = setup_q[BBPC_EN_BIT];
    end

    // read-only base bits read zero, so software can size the window
    assign xbase_word = {xbase_q & base_wmask, 6'h00};

    // capability header: id, next pointer, version, port type, slot bit
    always_comb begin
        caphdr_word        = 32'h00000000;
        caphdr_word[7:0]   = BBPC_CAP_ID;
        caphdr_word[15:8]  = BBPC_NEXT_PTR;
        caphdr_word[19:16] = BBPC_CAP_VER;
        caphdr_word[23:20] = reverse_q ? BBPC_PORT_REV : BBPC_PORT_FWD;
        caphdr_word[24]    = reverse_q;
        caphdr_word[29:25] = BBPC_MSG_NUM;
    end

    // device capability; reserved 17:15 and 31:28 left at zero
    always_comb begin
        devcap_word        = 32'h00000000;
        devcap_word[2:0]   = BBPC_MPS;
        devcap_word[4:3]   = BBPC_PHANTOM;
        devcap_word[5]     = BBPC_TAG8;
        devcap_word[8:6]   = BBPC_L0S_LAT;
        devcap_word[11:9]  = BBPC_L1_LAT;
        devcap_word[12]    = hp_present;
        devcap_word[13]    = hp_present;
        devcap_word[14]    = hp_present;
        devcap_word[25:18] = pwr_val_q;
        devcap_word[27:26] = pwr_scl_q;
    end

    // read mux; an unmapped address reads zero and flags an error
    always_comb begin
        case (req.addr)
            BBPC_OFF_XBASE:  rd_word = xbase_word;
            BBPC_OFF_SETUP:  rd_word = setup_word;
            BBPC_OFF_CAPHDR: rd_word = caphdr_word;
            BBPC_OFF_DEVCAP: rd_word = devcap_word;
            default:         rd_word = 32'h00000000;
        endcase
    end

    // software is trusted to keep mask bits 11:6 clear for memory space;
    // the hardware does not police it, so a wider mask just gives a smaller window

    // ---- checks beside the logic ----

    a_setup_type_zero: assert property (@(posedge clock) disable iff (rst)
        (pready && paddr == BBPC_OFF_SETUP) |-> (prdata[BBPC_TYPE_BIT] == 1'b0))
        else $error("window type selector read non-zero");

    a_addr_type_legal: assert property (@(posedge clock) disable iff (rst)
        (wr_en && pwrite && paddr == BBPC_OFF_SETUP) |=>
            (setup_q[BBPC_ATYPE_MSB:BBPC_ATYPE_LSB] == {1'b0, $past(pwdata[BBPC_ATYPE_LSB])}))
        else $error("address type took an illegal encoding");

    a_base_ro_bits: assert property (@(posedge clock) disable iff (rst)
        (wr_en && pwrite && paddr == BBPC_OFF_XBASE) |=>
            (((xbase_q ^ $past(pwdata[31:6])) & $past(base_wmask)) == 26'h0000000) &&
            (((xbase_q ^ $past(xbase_q)) & ~$past(base_wmask)) == 26'h0000000))
        else $error("translated base write ignored the size mask");

    a_window_enable: assert property (@(posedge clock) disable iff (rst)
        (wr_en && pwrite && paddr == BBPC_OFF_SETUP) |-> ##2
            (win_q.en == $past(pwdata[BBPC_EN_BIT], 2)))
        else $error("window enable did not follow the setup write");

    a_cap_header: assert property (@(posedge clock) disable iff (rst)
        (pready && paddr == BBPC_OFF_CAPHDR) |->
            (prdata[7:0] == BBPC_CAP_ID) && (prdata[15:8] == BBPC_NEXT_PTR))
        else $error("express_capability_identifier or next pointer wrong");

    a_port_mode: assert property (@(posedge clock) disable iff (rst)
        (pready && paddr == BBPC_OFF_CAPHDR) |->
            (prdata[24:20] == (reverse_q ? {1'b1, BBPC_PORT_REV} : {1'b0, BBPC_PORT_FWD})))
        else $error("port type or slot bit does not match bridge mode");

    a_devcap_fixed: assert property (@(posedge clock) disable iff (rst)
        (pready && paddr == BBPC_OFF_DEVCAP) |->
            (prdata[11:3] == {BBPC_L1_LAT, BBPC_L0S_LAT, BBPC_TAG8, BBPC_PHANTOM}))
        else $error("fixed device capability fields wrong");

    a_hotplug_bits: assert property (@(posedge clock) disable iff (rst)
        (pready && paddr == BBPC_OFF_DEVCAP) |->
            (prdata[14:12] == {3{hotplug_q && !reverse_q}}))
        else $error("hot-plug presence bits do not follow strap and mode");

    a_pwr_readback: assert property (@(posedge clock) disable iff (rst)
        (pready && paddr == BBPC_OFF_DEVCAP) |->
            (prdata[27:18] == $past({pwr_scl_q, pwr_val_q})))
        else $error("captured power limit not visible on read");

    a_reserved_zero: assert property (@(posedge clock) disable iff (rst)
        pready |->
            (paddr != BBPC_OFF_DEVCAP || (prdata[31:28] == 4'h0 && prdata[17:15] == 3'h0)) &&
            (paddr != BBPC_OFF_CAPHDR || prdata[31:30] == 2'h0) &&
            (paddr != BBPC_OFF_SETUP || (prdata[5:4] == 2'h0 && prdata[0] == 1'b0)) &&
            (paddr != BBPC_OFF_XBASE || prdata[5:0] == 6'h00))
        else $error("reserved bits read non-zero");

    a_unmapped_err: assert property (@(posedge clock) disable iff (rst)
        (psel && penable && !pready && !hit) |=> (pready && pslverr && prdata == 32'h00000000))
        else $error("unmapped access not answered with error");

    a_ro_write_ignored: assert property (@(posedge clock) disable iff (rst)
        (wr_en && pwrite && (paddr == BBPC_OFF_CAPHDR || paddr == BBPC_OFF_DEVCAP)) |=>
            $stable(setup_q) && $stable(xbase_q))
        else $error("write to read-only word changed state");

    a_unmapped_wr_drop: assert property (@(posedge clock) disable iff (rst)
        (pready && psel && penable && pwrite && !hit) |=> $stable(setup_q) && $stable(xbase_q))
        else $error("write to unmapped address changed state");

    a_setup_readback: assert property (@(posedge clock) disable iff (rst)
        (pready && paddr == BBPC_OFF_SETUP) |-> (prdata == ($past(setup_q) & BBPC_SETUP_WMASK)))
        else $error("setup word read back wrong");

    a_xbase_ro_read: assert property (@(posedge clock) disable iff (rst)
        (pready && paddr == BBPC_OFF_XBASE) |-> ((prdata[31:6] & ~$past(base_wmask)) == 26'h0000000))
        else $error("read-only base bit read non-zero");

    a_win_base_follows: assert property (@(posedge clock) disable iff (rst)
        (wr_en && pwrite && paddr == BBPC_OFF_XBASE) |-> ##2
            (win_q.base == ($past(pwdata[31:6], 2) & $past(base_wmask, 2))))
        else $error("window base does not follow the base write");

    a_win_mask_follows: assert property (@(posedge clock) disable iff (rst)
        (wr_en && pwrite && paddr == BBPC_OFF_SETUP) |-> ##2
            (win_q.size_mask == {1'b1, $past(pwdata[BBPC_SIZE_MSB:BBPC_SIZE_LSB], 2)}))
        else $error("window size mask does not follow the setup write");

    a_cap_version: assert property (@(posedge clock) disable iff (rst)
        (pready && paddr == BBPC_OFF_CAPHDR) |->
            (prdata[19:16] == BBPC_CAP_VER) && (prdata[29:25] == BBPC_MSG_NUM))
        else $error("capability version or message number wrong");

    a_max_payload: assert property (@(posedge clock) disable iff (rst)
        (pready && paddr == BBPC_OFF_DEVCAP) |-> (prdata[2:0] == BBPC_MPS))
        else $error("max payload field wrong");

    // straps may wander after reset; the reported mode must not follow them
    a_straps_frozen: assert property (@(posedge clock) disable iff (rst)
        !rst |=> $stable(reverse_q) && $stable(hotplug_q))
        else $error("bridge mode changed outside reset");

    // ---- handshake checks: one wait state, one-cycle answer ----

    a_ready_after_wait: assert property (@(posedge clock) disable iff (rst)
        (psel && penable && !pready) |=> pready)
        else $error("ready did not follow the single wait state");

    a_ready_pulse: assert property (@(posedge clock) disable iff (rst)
        pready |=> !pready)
        else $error("ready stood longer than one cycle");

    a_err_with_ready: assert property (@(posedge clock) disable iff (rst)
        pslverr |-> pready)
        else $error("error flag raised without ready");

    a_write_at_ready: assert property (@(posedge clock) disable iff (rst)
        wr_en |-> (pready && psel && penable))
        else $error("register write outside the completing edge");

    // read data must stand between answers, since a slow master may look late
    a_prdata_hold: assert property (@(posedge clock) disable iff (rst)
        !(psel && penable && !pready) |=> $stable(prdata))
        else $error("read data moved outside an answer");

    // ---- scenario covers ----

    c_setup_enable: cover property (@(posedge clock) disable iff (rst)
        wr_en && pwrite && paddr == BBPC_OFF_SETUP && pwdata[BBPC_EN_BIT]);

    c_base_write: cover property (@(posedge clock) disable iff (rst)
        wr_en && pwrite && paddr == BBPC_OFF_XBASE && setup_q[BBPC_SIZE_MSB]);

    c_pwr_message: cover property (@(posedge clock) disable iff (rst)
        slot_pwr.valid ##[1:20] (pready && paddr == BBPC_OFF_DEVCAP));

    c_unmapped: cover property (@(posedge clock) disable iff (rst)
        pready && pslverr);

    c_reverse_hotplug: cover property (@(posedge clock) disable iff (rst)
        pready && paddr == BBPC_OFF_DEVCAP && reverse_q && hotplug_q);

endmodule // bbpc_regs

// [tb_bridge_bar_setup_and_pcie_caps.sv]
// self-checking testbench for the window setup and express capability registers
`timescale 1ns/100ps
module tb_bridge_bar_setup_and_pcie_caps;
    import bbpc_pkg::*;

    logic        clock;
    logic        rst;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        reverse_strap;
    logic        hotplug_strap;
    bbpc_pwr_s   slot_pwr;
    bbpc_win_s   win_q;
    int          fails;
    int          comparisons;
    int          cycles;
    logic [31:0] rd;
    logic        err;

    bbpc_regs DUT (.clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
                   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
                   .pslverr(pslverr), .reverse_strap(reverse_strap), .hotplug_strap(hotplug_strap),
                   .slot_pwr(slot_pwr), .win_q(win_q));

    // 125 MHz clock
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    // hang guard: the whole run needs well under a thousand cycles
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles >= 5000) begin
            fails++;
            summarize();
        end
    end

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one apb transfer; request held until pready is seen high at an edge
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
        int n = 0;
        @(posedge clock);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= wd;
        @(posedge clock);
        penable <= 1'b1;
        // no cycle limit here; only the bench timeout ends a stuck wait
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1);
        chk("wait_states", 32'h00000002, n); // first access edge plus one wait state
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdchk(input string what, input logic [7:0] addr, input logic [31:0] exp,
                         input logic exp_err);
        apb(1'b0, addr, 32'h00000000);
        chk(what, exp, rd);
        chk("pslverr", {31'h0, exp_err}, {31'h0, err});
    endtask

    task automatic do_reset(input logic rev, input logic hp);
        @(posedge clock);
        rst           <= 1'b1;
        reverse_strap <= rev;
        hotplug_strap <= hp;
        repeat (5) @(posedge clock);
        rst <= 1'b0;
    endtask

    // reset values of every register for each strap combination
    task automatic t_straps();
        logic [1:0]  combo [4] = '{2'b10, 2'b11, 2'b00, 2'b01};
        logic [31:0] b0;
        logic [31:0] b4;
        for (int i = 0; i < 4; i++) begin
            do_reset(combo[i][1], combo[i][0]);
            b0 = {7'h00, combo[i][1], combo[i][1] ? 4'h8 : 4'h7, 4'h1, 8'hF0, 8'h10};
            b4 = {16'h0000, 1'b0, {3{combo[i][0] & ~combo[i][1]}}, 12'h022};
            chk("win_q", 32'h0, {8'h00, win_q[54:31]});
            rdchk("cap_header", BBPC_OFF_CAPHDR, b0, 1'b0);
            rdchk("dev_cap", BBPC_OFF_DEVCAP, b4, 1'b0);
            rdchk("setup_rst", BBPC_OFF_SETUP, 32'h00000000, 1'b0);
            rdchk("xbase_rst", BBPC_OFF_XBASE, 32'h00000000, 1'b0);
        end
    endtask

    // setup writes: writable bits only, window follows
    task automatic t_setup();
        logic [31:0] wv [4] = '{32'hFFFFF03F, 32'h00000035, 32'h00000002, 32'h80000008};
        logic [31:0] ev [4] = '{32'hFFFFF00A, 32'h00000000, 32'h00000002, 32'h80000008};
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, BBPC_OFF_SETUP, wv[i]);
            rdchk("setup", BBPC_OFF_SETUP, ev[i], 1'b0);
            chk("win_en", {31'h0, ev[i][31]}, {31'h0, win_q.en});
            chk("win_addr64", {31'h0, ev[i][1]}, {31'h0, win_q.addr64});
            chk("win_pref", {31'h0, ev[i][3]}, {31'h0, win_q.pref});
            chk("win_mask", {6'h00, 1'b1, ev[i][30:6]}, {6'h00, win_q.size_mask});
        end
    endtask

    // size mask decides which base bits can be written
    task automatic t_base();
        apb(1'b1, BBPC_OFF_SETUP, 32'h80FFF000);
        apb(1'b1, BBPC_OFF_XBASE, 32'hFFFFFFFF);
        rdchk("xbase", BBPC_OFF_XBASE, 32'h80FFF000, 1'b0);
        repeat (2) @(posedge clock);
        chk("win_base", 32'h0203FFC0, {6'h00, win_q.base});
        chk("win_en", 32'h1, {31'h0, win_q.en});
        apb(1'b1, BBPC_OFF_SETUP, 32'h80000000);
        apb(1'b1, BBPC_OFF_XBASE, 32'h7FFFFFC0);
        rdchk("xbase_ro", BBPC_OFF_XBASE, 32'h00000000, 1'b0);
    endtask

    // read-only words ignore writes, unmapped places answer with an error
    task automatic t_readonly();
        apb(1'b1, BBPC_OFF_CAPHDR, 32'h00000000);
        chk("wr_err_b0", 32'h0, {31'h0, err});
        apb(1'b1, BBPC_OFF_DEVCAP, 32'hFFFFFFFF);
        rdchk("cap_header", BBPC_OFF_CAPHDR, 32'h0071F010, 1'b0);
        rdchk("dev_cap", BBPC_OFF_DEVCAP, 32'h00007022, 1'b0);
        apb(1'b1, 8'hC0, 32'hFFFFFFFF);
        chk("wr_err_c0", 32'h1, {31'h0, err});
        rdchk("unmapped", 8'hC0, 32'h00000000, 1'b1);
        rdchk("unmapped_lo", 8'h00, 32'h00000000, 1'b1);
    endtask

    // power limit messages load value and scale; reset clears them
    task automatic t_power();
        logic [9:0] msg [2] = '{{8'hA5, 2'h3}, {8'h5A, 2'h1}};
        for (int i = 0; i < 2; i++) begin
            @(posedge clock);
            slot_pwr <= {1'b1, msg[i]};
            @(posedge clock);
            slot_pwr <= {1'b0, 8'h00, 2'h0};
            rdchk("dev_cap_pwr", BBPC_OFF_DEVCAP, {4'h0, msg[i][1:0], msg[i][9:2], 18'h07022}, 1'b0);
        end
        do_reset(1'b0, 1'b1);
        rdchk("dev_cap_clr", BBPC_OFF_DEVCAP, 32'h00007022, 1'b0);
    endtask

    // main sequence; all inputs defined at time zero
    initial begin
        fails         = 0;
        comparisons   = 0;
        cycles        = 0;
        rst           = 1'b1;
        psel          = 1'b0;
        penable       = 1'b0;
        pwrite        = 1'b0;
        paddr         = 8'h00;
        pwdata        = 32'h00000000;
        reverse_strap = 1'b0;
        hotplug_strap = 1'b1;
        slot_pwr      = {1'b0, 8'h00, 2'h0};
        t_straps();
        t_setup();
        t_base();
        t_readonly();
        t_power();
        summarize();
    end

endmodule // tb_bridge_bar_setup_and_pcie_caps
